/* rtl/sar_ctrl_pkg.sv */
// Shared constants, timing counts, state codes and pin carriers for the
// blank/convert controller of a 10-bit successive approximation converter.
// Assumes a single 100 MHz clock drives every user of this package.
package sar_ctrl_pkg;

    // Result width and counter sizing
    localparam int RESULT_W = 10;
    localparam int BIT_IDX_W = 4;
    localparam int CNT_W = 10;

    // Clock period of ref_clk
    localparam int CLK_PERIOD_NS = 10;

    // Whole conversion budget, shared evenly among the result bits
    localparam int CONV_MAX_NS = 40000;
    localparam int STEP_NS = CONV_MAX_NS / RESULT_W;
    localparam int STEP_CYC = STEP_NS / CLK_PERIOD_NS;

    // Longest wait from result-valid low to data enabled (round down)
    localparam int DATA_EN_NS = 500;
    localparam int DATA_EN_CYC = (DATA_EN_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 DATA_EN_NS / CLK_PERIOD_NS;

    // Delay from line high to blanking of a shown result
    localparam int BLANK_DELAY_NS = 1500;
    localparam int BLANK_CYC = BLANK_DELAY_NS / CLK_PERIOD_NS;

    // Least high pulse that clears a conversion in progress (round up)
    localparam int ABORT_PULSE_NS = 2000;
    localparam int ABORT_CYC = (ABORT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Controller states, one-hot
    typedef enum logic [5:0] {
        ST_STANDBY  = 6'h01,
        ST_CONVERT  = 6'h02,
        ST_HALTED   = 6'h04,
        ST_REVEAL   = 6'h08,
        ST_SHOW     = 6'h10,
        ST_BLANKING = 6'h20
    } conv_state_t;

    // Three-state result bus: value plus active-low output enable
    typedef struct packed {
        logic [RESULT_W-1:0] value;
        logic oe_n;
    } data_bus_t;

    // Open-drain pin: driven level plus active-low output enable
    typedef struct packed {
        logic level;
        logic oe_n;
    } od_pin_t;

endpackage

/* rtl/pin_sync.sv */
// Two-flop synchroniser for one asynchronous pin level.
// Assumes the pin is a level; the first flop feeds only the second.
`timescale 1ns/1ps
module pin_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic pin_in,
    output logic level_out
);

    logic meta_reg;

    // First stage is read by the second stage only, to contain metastability
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b1;
            level_out <= 1'b1;
        end else if (clk_en) begin
            meta_reg <= pin_in;
            level_out <= meta_reg;
        end
    end

endmodule

/* rtl/sar_adc_blank_convert_control.sv */
// Blank/convert sequencing and successive approximation register for a
// 10-bit converter with three-state data outputs and open-drain ready.
// Assumes blank_convert_n and comp_above arrive asynchronously from pins,
// and that the board pulls result_valid_n high when nobody drives it.
`timescale 1ns/1ps
// Contract
// [RULE_01] Line high: outputs open, result-valid high
// [RULE_02] Falling line starts conversion, outputs unchanged
// [RULE_03] Done: valid low, data on within 500ns
// [RULE_04] Line high 1.5us: valid high, outputs open
// [RULE_05] Host holds line high 2us to restart
// [RULE_06] Line high mid-conversion halts, outputs unchanged
// [RULE_07] High pulse 2us clears, fall restarts conversion
// [RULE_08] Pulse mode: line low, positive start pulses
// [RULE_09] Shared bus: select low, wait, read, raise
// [RULE_10] Overlapped converters: blank first within 15us
// [RULE_11] Sample-hold held by line and valid feedback
// [RULE_12] Host start pulse ends when valid rises
// [RULE_13] Line low after completion keeps result driven
// [RULE_14] Host reads result as left-justified bytes
// [RULE_15] Host polls buffered result-valid copy
// [RULE_16] Result-valid is open-drain, wire-OR capable
// [RULE_17] Only one converter drives shared data
// [RULE_18] Successive approximation, MSB first, present after LSB
module sar_adc_blank_convert_control
    import sar_ctrl_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYC,
    parameter int DATA_EN_CYCLES = DATA_EN_CYC,
    parameter int BLANK_CYCLES = BLANK_CYC,
    parameter int ABORT_CYCLES = ABORT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic blank_convert_n,
    input wire logic comp_above,
    output logic [RESULT_W-1:0] dac_code,
    output data_bus_t data_bus,
    output od_pin_t result_valid_n
);

    // Counters are CNT_W wide; refuse settings that would not fit. A step needs
    // four cycles: one to the DAC register, two through the comparator
    // synchroniser and one to decide, so anything shorter decides on stale data.
    if (STEP_CYCLES < 4 || STEP_CYCLES >= (1 << CNT_W)) begin : g_step_chk
        $error("STEP_CYCLES out of range");
    end
    if (DATA_EN_CYCLES < 1 || DATA_EN_CYCLES >= (1 << CNT_W)) begin : g_data_en_chk
        $error("DATA_EN_CYCLES out of range");
    end
    if (BLANK_CYCLES < 1 || BLANK_CYCLES >= (1 << CNT_W)) begin : g_blank_chk
        $error("BLANK_CYCLES out of range");
    end
    if (ABORT_CYCLES < 1 || ABORT_CYCLES >= (1 << CNT_W)) begin : g_abort_chk
        $error("ABORT_CYCLES out of range");
    end

    localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);
    localparam logic [CNT_W-1:0] DATA_EN_LAST = CNT_W'(DATA_EN_CYCLES - 1);
    localparam logic [CNT_W-1:0] BLANK_LAST = CNT_W'(BLANK_CYCLES - 1);
    localparam logic [CNT_W-1:0] ABORT_LAST = CNT_W'(ABORT_CYCLES - 1);
    localparam logic [BIT_IDX_W-1:0] MSB_IDX = BIT_IDX_W'(RESULT_W - 1);

    conv_state_t state_reg;
    logic [CNT_W-1:0] timer_reg;
    logic [CNT_W-1:0] step_reg;
    logic [BIT_IDX_W-1:0] bit_idx_reg;
    logic [RESULT_W-1:0] code_reg;
    logic complete_reg;
    logic line_high;
    logic line_prev_reg;
    logic comp_level;
    logic line_fall;
    logic start_fresh;
    logic step_end;

    // Both pins cross into ref_clk through two flops before any use
    pin_sync u_sync_line (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .pin_in(blank_convert_n),
        .level_out(line_high)
    );

    pin_sync u_sync_comp (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .pin_in(comp_above),
        .level_out(comp_level)
    );

    // Previous synchronised line level, for edge detection
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            line_prev_reg <= 1'b1;
        end else if (clk_en) begin
            line_prev_reg <= line_high;
        end
    end

    // Edge and step decode
    assign line_fall = line_prev_reg && !line_high;
    assign start_fresh = (state_reg == ST_STANDBY) && line_fall;
    assign step_end = (state_reg == ST_CONVERT) && !line_high && !complete_reg &&
                      (step_reg == STEP_LAST);

    // Sequencing of standby, conversion, halt, reveal, show and blanking
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_STANDBY;
            timer_reg <= '0;
        end else if (clk_en) begin
            case (state_reg)
                ST_STANDBY: begin
                    timer_reg <= '0;
                    if (line_fall) begin
                        state_reg <= ST_CONVERT; // [RULE_02]
                    end
                end
                ST_CONVERT: begin
                    timer_reg <= '0;
                    if (line_high) begin
                        state_reg <= ST_HALTED; // [RULE_06]
                    end else if (complete_reg) begin
                        state_reg <= ST_REVEAL; // [RULE_03]
                    end
                end
                ST_HALTED: begin
                    // A short pulse only pauses; a long one abandons the work
                    if (!line_high) begin
                        state_reg <= ST_CONVERT; // [RULE_06]
                    end else if (timer_reg == ABORT_LAST) begin
                        state_reg <= ST_STANDBY; // [RULE_07]
                    end else begin
                        timer_reg <= timer_reg + 1'b1;
                    end
                end
                ST_REVEAL: begin
                    if (line_high) begin
                        state_reg <= ST_BLANKING;
                        timer_reg <= '0;
                    end else if (timer_reg == DATA_EN_LAST) begin
                        state_reg <= ST_SHOW; // [RULE_03]
                        timer_reg <= '0;
                    end else begin
                        timer_reg <= timer_reg + 1'b1;
                    end
                end
                ST_SHOW: begin
                    timer_reg <= '0;
                    if (line_high) begin
                        state_reg <= ST_BLANKING; // [RULE_04]
                    end
                end
                ST_BLANKING: begin
                    // Dropping the line early keeps the old result on show
                    if (!line_high) begin
                        state_reg <= ST_SHOW; // [RULE_13]
                        timer_reg <= '0;
                    end else if (timer_reg == BLANK_LAST) begin
                        state_reg <= ST_STANDBY; // [RULE_04]
                        timer_reg <= '0;
                    end else begin
                        timer_reg <= timer_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_STANDBY;
                    timer_reg <= '0;
                end
            endcase
        end
    end

    // Bit timer: frozen while halted so a short pulse resumes in place
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            step_reg <= '0;
        end else if (clk_en) begin
            if (start_fresh || step_end) begin
                step_reg <= '0;
            end else if (state_reg == ST_CONVERT && !line_high && !complete_reg) begin
                step_reg <= step_reg + 1'b1;
            end
        end
    end

    // Successive approximation: trial bit set, comparator keeps or drops it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            code_reg <= '0;
            bit_idx_reg <= MSB_IDX;
            complete_reg <= 1'b0;
        end else if (clk_en) begin
            if (start_fresh) begin
                code_reg <= '0;
                code_reg[RESULT_W-1] <= 1'b1; // [RULE_18]
                bit_idx_reg <= MSB_IDX;
                complete_reg <= 1'b0; // [RULE_07]
            end else if (step_end) begin
                code_reg[bit_idx_reg] <= comp_level; // [RULE_18]
                if (bit_idx_reg == '0) begin
                    complete_reg <= 1'b1; // [RULE_18]
                end else begin
                    code_reg[bit_idx_reg - 1'b1] <= 1'b1;
                    bit_idx_reg <= bit_idx_reg - 1'b1;
                end
            end
        end
    end

    // Trial code toward the DAC
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dac_code <= '0;
        end else if (clk_en) begin
            dac_code <= code_reg;
        end
    end

    // Result pins: value loaded once the last bit has been decided; the enable
    // holds its level in every state but the deciding ones, which keeps the
    // pins untouched across halts and early line drops.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_bus.value <= '0;
            data_bus.oe_n <= 1'b1;
        end else if (clk_en) begin
            if (state_reg == ST_REVEAL) begin
                data_bus.value <= code_reg; // [RULE_18]
            end
            if (state_reg == ST_STANDBY) begin
                data_bus.oe_n <= 1'b1; // [RULE_01] [RULE_04]
            end else if (state_reg == ST_SHOW) begin
                data_bus.oe_n <= 1'b0; // [RULE_03] [RULE_13]
            end
        end
    end

    // Open-drain ready: only ever pulls low, the pull-up supplies the high level
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            result_valid_n.level <= 1'b0;
            result_valid_n.oe_n <= 1'b1;
        end else if (clk_en) begin
            result_valid_n.level <= 1'b0; // [RULE_16]
            if (state_reg == ST_STANDBY) begin
                result_valid_n.oe_n <= 1'b1; // [RULE_01] [RULE_04]
            end else if (state_reg == ST_REVEAL) begin
                result_valid_n.oe_n <= 1'b0; // [RULE_03]
            end
        end
    end

endmodule

/* verification/sar_ctrl_checker.sv */
// Checker for the timing relations of the result and ready outputs.
// Assumes it is bound into the converter control top module.
`timescale 1ns/1ps
module sar_ctrl_checker
    import sar_ctrl_pkg::*;
#(
    parameter int DATA_EN_CYCLES = 2,
    parameter int BLANK_CYCLES = 5
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic blank_convert_n,
    input wire logic comp_above,
    input wire logic [RESULT_W-1:0] dac_code,
    input wire data_bus_t data_bus,
    input wire od_pin_t result_valid_n
);
    localparam int DEN_M1 = DATA_EN_CYCLES - 1;
    logic [7:0] hi_cnt;
    logic [7:0] lo_cnt;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // Run lengths of the raw line; margins cover the synchroniser lag
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hi_cnt <= 8'h00;
            lo_cnt <= 8'h00;
        end else begin
            hi_cnt <= !blank_convert_n ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hff};
            lo_cnt <= blank_convert_n ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hff};
        end
    end
    a_ready_drives_low: assert property (result_valid_n.level == 1'b0)
        else $error("ready pin drives high");
    a_data_after_ready: assert property ($fell(result_valid_n.oe_n) |->
        data_bus.oe_n ##DEN_M1 data_bus.oe_n ##1 !data_bus.oe_n)
        else $error("data enable not on time after ready");
    a_data_needs_ready: assert property (!data_bus.oe_n |-> !result_valid_n.oe_n)
        else $error("data driven without ready");
    a_standby_quiet: assert property (hi_cnt > 8'(BLANK_CYCLES + 8) |->
        result_valid_n.oe_n && data_bus.oe_n)
        else $error("outputs active in standby");
    a_blank_not_early: assert property ($rose(result_valid_n.oe_n) |->
        hi_cnt >= 8'(BLANK_CYCLES))
        else $error("result blanked too early");
    a_fall_no_change: assert property ($fell(blank_convert_n) && result_valid_n.oe_n |=>
        (result_valid_n.oe_n && data_bus.oe_n) [*2])
        else $error("outputs moved at start");
    a_shown_result_stable: assert property (!data_bus.oe_n && $past(data_bus.oe_n) == 1'b0
        |-> $stable(data_bus.value))
        else $error("shown result changed");
    a_hold_while_low: assert property (!result_valid_n.oe_n && lo_cnt > 8'd8
        |=> !result_valid_n.oe_n)
        else $error("ready dropped while line low");
    a_dac_tracks_result: assert property (!data_bus.oe_n |->
        dac_code == data_bus.value)
        else $error("trial code differs from shown result");
endmodule

/* verification/sar_front_model.sv */
// Analog front end model: sample-hold ahead of a comparator on the trial code.
// Assumes the bench supplies the input level and the resolved ready wire.
`timescale 1ns/1ps
module sar_front_model
    import sar_ctrl_pkg::*;
(
    input wire logic [RESULT_W-1:0] analog_in,
    input wire logic [RESULT_W-1:0] dac_code,
    input wire logic blank_convert_n,
    input wire logic ready_wire_n,
    output logic comp_above
);
    logic [RESULT_W-1:0] held;
    // Holds while converting so the input cannot move under the search
    always @* begin
        if (blank_convert_n || !ready_wire_n) begin
            held = analog_in;
        end
    end
    // Decision: 1 keeps the trial bit
    assign comp_above = (held >= dac_code);
endmodule

/* verification/test_sar_adc_blank_convert_control.sv */
// Self-checking bench for the blank/convert controller with short counts.
// Assumes the package, design, checker and front end model compile first.
`timescale 1ns/1ps
module test_sar_adc_blank_convert_control
    import sar_ctrl_pkg::*;
();
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic blank_convert_n = 1'b1;
    logic comp_above;
    logic [RESULT_W-1:0] analog_in = 10'h000;
    logic [RESULT_W-1:0] dac_code;
    data_bus_t data_bus;
    od_pin_t result_valid_n;
    logic rv_wire;
    logic [RESULT_W-1:0] exp_q[$];
    int n_fail = 0;
    int tests_run = 0;
    int seed = 97;
    int i;
    logic [7:0] word_hi;
    logic [7:0] word_lo;
    always #5 ref_clk = ~ref_clk;
    // Pull-up on the open-drain ready line
    assign rv_wire = result_valid_n.oe_n ? 1'b1 : result_valid_n.level;
    sar_adc_blank_convert_control #(.STEP_CYCLES(4), .DATA_EN_CYCLES(2), .BLANK_CYCLES(5),
        .ABORT_CYCLES(8)) dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .blank_convert_n(blank_convert_n), .comp_above(comp_above), .dac_code(dac_code),
        .data_bus(data_bus), .result_valid_n(result_valid_n));
    sar_front_model fe_u (.analog_in(analog_in), .dac_code(dac_code),
        .blank_convert_n(blank_convert_n), .ready_wire_n(rv_wire), .comp_above(comp_above));
    task automatic end_sim();
        $display("Checks %0d, errors %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    // Line changes just after an edge; returns at a falling edge, outputs settled
    task automatic line(input logic v, input int cyc);
        @(posedge ref_clk);
        blank_convert_n <= v;
        repeat (cyc) @(negedge ref_clk);
    endtask
    // Bounded wait on the ready wire; a hang ends the run
    task automatic wait_rv(input logic lvl);
        for (int k = 0; k < 300 && rv_wire !== lvl; k++) @(negedge ref_clk);
        check(rv_wire === lvl, "ready wait timed out");
        if (rv_wire !== lvl) end_sim();
    endtask
    task automatic start(input logic [RESULT_W-1:0] v, input logic note);
        @(posedge ref_clk);
        analog_in <= v;
        if (note) exp_q.push_back(v);
        line(1'b0, 1);
    endtask
    task automatic finish();
        wait_rv(1'b0);
        repeat (4) @(negedge ref_clk);
    endtask
    // Result appears when data enable falls; the host reads it as two bus words,
    // upper bits left-justified in the first; oldest note is the expected code
    always @(negedge data_bus.oe_n) begin
        word_hi = data_bus.value[RESULT_W-1:RESULT_W-8];
        word_lo = {data_bus.value[RESULT_W-9:0], 6'h00};
        check(exp_q.size() > 0, "unexpected result");
        if (exp_q.size() > 0) begin
            check({word_hi, word_lo[7:6]} === exp_q.pop_front(), "bad result");
        end
        check(rv_wire === 1'b0, "data before ready");
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(negedge ref_clk);
        check(data_bus.oe_n === 1'b1 && rv_wire === 1'b1, "standby not open");
        // Shared-bus cycles: boundary codes first, then random ones
        for (i = 0; i < 8; i++) begin
            start(i == 0 ? 10'h000 : i == 1 ? 10'h3ff : 10'($random(seed)), 1'b1);
            finish();
            line(1'b1, 2);
            check(rv_wire === 1'b0 && data_bus.oe_n === 1'b0, "blanked early");
            wait_rv(1'b1);
            check(data_bus.oe_n === 1'b1, "data left driven");
            line(1'b1, 20);
        end
        // Short high pulse and a clock-enable gap pause the search, which then resumes
        start(10'h155, 1'b1);
        line(1'b1, 3);
        check(rv_wire === 1'b1 && data_bus.oe_n === 1'b1, "halt moved outputs");
        line(1'b0, 6);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (6) @(posedge ref_clk);
        clk_en <= 1'b1;
        finish();
        // Long pulse clears; the new input must win over the abandoned search
        line(1'b1, 20);
        // Upper bits settle high before the abort, so a resumed search would show
        start(10'h3ff, 1'b0);
        line(1'b0, 20);
        @(posedge ref_clk);
        analog_in <= 10'h000;
        exp_q.push_back(10'h000);
        line(1'b1, 12);
        line(1'b0, 1);
        finish();
        // Pulse mode: line stays low, result stays, host pulse ends on ready
        repeat (30) @(negedge ref_clk);
        check(rv_wire === 1'b0 && data_bus.oe_n === 1'b0, "result not held");
        line(1'b1, 2);
        line(1'b0, 10);
        check(rv_wire === 1'b0 && data_bus.oe_n === 1'b0, "short high blanked");
        for (i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            analog_in <= 10'($random(seed));
            @(negedge ref_clk);
            exp_q.push_back(analog_in);
            line(1'b1, 1);
            wait_rv(1'b1);
            line(1'b0, 1);
            finish();
        end
        check(exp_q.size() == 0, "results missing");
        end_sim();
    end
endmodule
bind sar_adc_blank_convert_control sar_ctrl_checker #(.DATA_EN_CYCLES(DATA_EN_CYCLES),
    .BLANK_CYCLES(BLANK_CYCLES)) chk_u (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .blank_convert_n(blank_convert_n), .comp_above(comp_above), .dac_code(dac_code),
    .data_bus(data_bus), .result_valid_n(result_valid_n));
